// ### rtl/logic_cell_defines.vh
`ifndef LOGIC_CELL_DEFINES_VH
`define LOGIC_CELL_DEFINES_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_TOP_MASK_LO 8'h04
`define OFS_TOP_MASK_HI 8'h08
`define OFS_BOT_MASK_LO 8'h0C
`define OFS_BOT_MASK_HI 8'h10
`define OFS_STATUS 8'h14

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_PACK_TOP 3
`define CTRL_PACK_BOT 4
`define CTRL_CHAIN_TOP 5
`define CTRL_CHAIN_BOT 6
`define CTRL_SCLR_EN_TOP 7
`define CTRL_SLOAD_EN_TOP 8
`define CTRL_SCLR_EN_BOT 9
`define CTRL_SLOAD_EN_BOT 10
`define CTRL_COMB_OUT 11
`define CTRL_CHAIN_START 12
`define CTRL_BYPASS 13
`define CTRL_LOCAL_CTL 14
`define CTRL_WIDTH 15

// Reset values
`define CTRL_RESET 15'h0000
`define MASK_RESET 32'h00000000

// Operating modes
`define MODE_NORMAL 3'h0
`define MODE_EXT_LUT 3'h1
`define MODE_ARITH 3'h2
`define MODE_SHARED 3'h3
`define MODE_LUT_REG 3'h4

// Chain geometry
`define CELLS_PER_CLUSTER 10
`define BITS_PER_CELL 2
`define CARRY_START_LO 0
`define CARRY_START_HI 4
`define SHARE_START_LO 0
`define SHARE_START_HI 5
`define HALF_CELLS 5

`endif

// ### rtl/lut_table.v
`default_nettype none

// Lookup table: the mask bit addressed by the select inputs
module lut_table #(
  parameter N = 4
) (
  // Truth table
  input wire [(1<<N)-1:0] mask,
  // Inputs
  input wire [N-1:0] sel,
  // Result
  output wire out
);

  assign out = mask[sel];

endmodule // lut_table

`default_nettype wire

// ### rtl/cell_register.v
`default_nettype none

// One cell register with cluster-wide controls
module cell_register (
  // Clock and clear
  input wire clk,
  input wire clr_n,
  // Synchronous controls
  input wire ena,
  input wire sclr,
  input wire sload,
  input wire sdata,
  // Data
  input wire d,
  output reg q
);

  // Clear beats everything; sclr beats sload; both wait for ena
  always @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      q <= 1'b0;
    end else if (ena) begin
      if (sclr) begin
        q <= 1'b0;
      end else if (sload) begin
        q <= sdata;
      end else begin
        q <= d;
      end
    end
  end

endmodule // cell_register

`default_nettype wire

// ### rtl/logic_cell.v
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "logic_cell_defines.vh"
`default_nettype none

// How it works
// - The cell runs in exactly one of five modes, set in the control register.
// - Eleven inputs: eight data, carry-in, shared-chain-in, register-chain-in.
// - Registers take clock, enable, clears and load from cluster-wide controls.
// - Normal mode: two functions, or one function of up to six inputs.
// - Two five-input functions share lut_in_a and lut_in_b; four-with-five share one.
// - Two six-input functions fit only with four shared inputs and identical logic; here top and bottom masks are separate, so the logic may differ.
// - Six inputs use a-d plus e0/f0 to top, or e1/f1 to bottom.
// - Bottom six-input use frees e0/f0; f1 packs only if unregistered.
// - Extended mode muxes two five-input functions; eighth input packs, bottom unavailable.
// - Arithmetic mode: four four-input tables feed two full adders, sharing a and b.
// - Carry-in enters first adder, then second adder, then next cell.
// - Arithmetic results come out registered, unregistered, or both.
// - Carry output can be used with table outputs; sums are then dropped, though here the top and bottom registers still load them.
// - Local enable, counter enable, up/down, add/sub; per-register sclr/sload enables.
// - Two-bit carry select inside the cell; carry starts at first or fifth cell.
// - Chains over twenty bits continue to the next cluster, up to a column.
// - Top-half chains continue in top half, bottom-half chains in bottom half.
// - Alternate columns bypass top half, others bottom half; bypassed cells stay free.
// - Shared mode: four tables make sum or carry of three inputs.
// - Shared carry goes to second adder or next cell; starts at first or sixth.
// - Lookup-table-register mode adds a third register sharing only clock, clear and clk_ena with the top register, without sclr or sload.
// - Chip-wide clear resets every register and overrides all other controls.
// - Register-chain input feeds a register directly for shift registers.
module logic_cell #(
  parameter CELL_INDEX = 0,
  parameter COLUMN_ODD = 0,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Cluster-wide controls
  input wire clk_ena,
  input wire aclr_n,
  input wire sclr,
  input wire sload,
  input wire chip_wide_clear_n,
  // Local data inputs
  input wire lut_in_a,
  input wire lut_in_b,
  input wire lut_in_c,
  input wire lut_in_d,
  input wire lut_in_e0,
  input wire lut_in_f0,
  input wire lut_in_e1,
  input wire lut_in_f1,
  // Chains from the previous cell
  input wire carry_in,
  input wire share_in,
  input wire reg_chain_in,
  // Chains to the next cell
  output wire carry_out,
  output wire share_out,
  output wire reg_chain_out,
  // Output drivers
  output wire top_comb_out,
  output wire top_reg_out,
  output wire bot_comb_out,
  output wire bot_reg_out,
  output wire lut_reg_out
);

  reg [`CTRL_WIDTH-1:0] ctrl_r;
  reg [31:0] top_lo_r;
  reg [31:0] top_hi_r;
  reg [31:0] bot_lo_r;
  reg [31:0] bot_hi_r;
  reg [31:0] rdata_nxt;

  wire [2:0] mode_raw;
  reg [2:0] mode;
  wire mode_bad;
  wire [63:0] top_mask;
  wire [63:0] bot_mask;
  wire clr_n;
  wire top_q;
  wire bot_q;
  wire lut_q;

  // Half-cluster membership of this cell
  function in_top_half;
    input integer idx;
    begin
      in_top_half = (idx < `HALF_CELLS);
    end
  endfunction

  // One full adder, returns {carry, sum}
  function [1:0] fadd;
    input x;
    input y;
    input c;
    begin
      fadd = {(x & y) | (x & c) | (y & c), x ^ y ^ c};
    end
  endfunction

  // Register port writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `CTRL_RESET;
      top_lo_r <= `MASK_RESET;
      top_hi_r <= `MASK_RESET;
      bot_lo_r <= `MASK_RESET;
      bot_hi_r <= `MASK_RESET;
    end else if (wr) begin
      case (addr)
        `OFS_CTRL: ctrl_r <= wdata[`CTRL_WIDTH-1:0];
        `OFS_TOP_MASK_LO: top_lo_r <= wdata;
        `OFS_TOP_MASK_HI: top_hi_r <= wdata;
        `OFS_BOT_MASK_LO: bot_lo_r <= wdata;
        `OFS_BOT_MASK_HI: bot_hi_r <= wdata;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  assign top_mask = {top_hi_r, top_lo_r};
  assign bot_mask = {bot_hi_r, bot_lo_r};

  // Unused mode codes fall back to normal so one mode is always in force
  assign mode_raw = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign mode_bad = (mode_raw > `MODE_LUT_REG);
  always @* begin
    if (mode_bad) begin
      mode = `MODE_NORMAL;
    end else begin
      mode = mode_raw;
    end
  end

  wire is_ext = (mode == `MODE_EXT_LUT);
  wire is_arith = (mode == `MODE_ARITH);
  wire is_shared = (mode == `MODE_SHARED);
  wire is_lutreg = (mode == `MODE_LUT_REG);
  wire is_add = is_arith | is_shared;

  wire pack_top = ctrl_r[`CTRL_PACK_TOP];
  wire pack_bot = ctrl_r[`CTRL_PACK_BOT];
  wire chain_top = ctrl_r[`CTRL_CHAIN_TOP];
  wire chain_bot = ctrl_r[`CTRL_CHAIN_BOT];
  wire comb_out = ctrl_r[`CTRL_COMB_OUT];
  wire local_ctl = ctrl_r[`CTRL_LOCAL_CTL] & is_arith;

  // Six-input tables: a-d shared, e0/f0 top, e1/f1 bottom
  wire top6;
  wire bot6;
  lut_table #(.N(6)) u_top6 (
    .mask(top_mask),
    .sel({lut_in_f0, lut_in_e0, lut_in_d, lut_in_c, lut_in_b, lut_in_a}),
    .out(top6)
  );
  lut_table #(.N(6)) u_bot6 (
    .mask(bot_mask),
    .sel({lut_in_f1, lut_in_e1, lut_in_d, lut_in_c, lut_in_b, lut_in_a}),
    .out(bot6)
  );

  // Two five-input halves sharing four inputs, muxed by f0
  wire five0;
  wire five1;
  lut_table #(.N(5)) u_five0 (
    .mask(top_lo_r),
    .sel({lut_in_e0, lut_in_d, lut_in_c, lut_in_b, lut_in_a}),
    .out(five0)
  );
  lut_table #(.N(5)) u_five1 (
    .mask(bot_lo_r),
    .sel({lut_in_e1, lut_in_d, lut_in_c, lut_in_b, lut_in_a}),
    .out(five1)
  );
  wire ext_out = lut_in_f0 ? five1 : five0;

  // Four four-input tables, all sharing lut_in_a and lut_in_b
  wire [3:0] q4;
  wire [3:0] var_hi = {lut_in_f1, lut_in_e1, lut_in_f0, lut_in_e0};
  wire [63:0] mask4 = {bot_mask[31:16], bot_mask[15:0], top_mask[31:16], top_mask[15:0]};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lut4
      lut_table #(.N(4)) u_lut4 (
        .mask(mask4[g*16 +: 16]),
        .sel({var_hi[g], (g % 2 == 0) ? lut_in_c : lut_in_d, lut_in_b, lut_in_a}),
        .out(q4[g])
      );
    end
  endgenerate

  // Local counter controls taken from data inputs
  wire loc_ena = local_ctl ? lut_in_f0 : 1'b1;
  wire cnt_en = local_ctl ? lut_in_f1 : 1'b1;
  wire up_dn = local_ctl ? lut_in_e1 : 1'b1;
  wire add_sub = local_ctl ? lut_in_e0 : 1'b1;
  wire invert = is_arith & (~add_sub | ~up_dn);

  // Chain start and bypass limited by cell position and column
  wire start_ok = is_shared ?
    (CELL_INDEX == `SHARE_START_LO || CELL_INDEX == `SHARE_START_HI) :
    (CELL_INDEX == `CARRY_START_LO || CELL_INDEX == `CARRY_START_HI);
  wire chain_start = ctrl_r[`CTRL_CHAIN_START] & start_ok & is_add;
  wire bypass_ok = COLUMN_ODD ? !in_top_half(CELL_INDEX) : in_top_half(CELL_INDEX);
  wire bypass = ctrl_r[`CTRL_BYPASS] & bypass_ok & !is_add;

  wire cin_eff = chain_start ? invert : carry_in;
  wire sin_eff = chain_start ? 1'b0 : share_in;

  // Adder operands per mode
  wire x0 = q4[0];
  wire x1 = q4[2];
  wire y0 = is_shared ? sin_eff : (q4[1] ^ invert);
  wire y1 = is_shared ? q4[1] : (q4[3] ^ invert);

  // Two-bit carry select: second bit precomputed for both carries
  wire [1:0] add0 = fadd(x0, y0, cin_eff);
  wire [1:0] add1_c0 = fadd(x1, y1, 1'b0);
  wire [1:0] add1_c1 = fadd(x1, y1, 1'b1);
  wire [1:0] add1 = add0[1] ? add1_c1 : add1_c0;

  // Pass-through keeps a chain running past a bypassed cell
  assign carry_out = bypass ? carry_in : (is_add ? add1[1] : 1'b0);
  assign share_out = bypass ? share_in : (is_shared ? q4[3] : 1'b0);

  // Combinational results per mode
  reg top_src;
  reg bot_src;
  always @* begin
    case (mode)
      `MODE_EXT_LUT: begin
        top_src = ext_out;
        bot_src = 1'b0;
      end
      `MODE_ARITH, `MODE_SHARED: begin
        top_src = add0[0];
        bot_src = add1[0];
      end
      default: begin
        top_src = top6;
        bot_src = bot6;
      end
    endcase
  end

  // Carry with table outputs drops the sums
  wire use_tables = is_arith & comb_out;
  assign top_comb_out = use_tables ? x0 : top_src;
  assign bot_comb_out = use_tables ? x1 : bot_src;

  // Register packing and register-chain selection
  wire top_pack = is_ext ? lut_in_f1 : lut_in_e0;
  wire top_d = chain_top ? reg_chain_in : (pack_top ? top_pack : top_src);
  wire bot_d = chain_bot ? top_q : (pack_bot ? lut_in_f1 : bot_src);

  // Chip-wide clear overrides every other control
  assign clr_n = nrst & aclr_n & chip_wide_clear_n;

  wire reg_ena = clk_ena & loc_ena & cnt_en;
  wire top_sclr = sclr & ctrl_r[`CTRL_SCLR_EN_TOP];
  wire top_sload = sload & ctrl_r[`CTRL_SLOAD_EN_TOP];
  wire bot_sclr = sclr & ctrl_r[`CTRL_SCLR_EN_BOT];
  wire bot_sload = sload & ctrl_r[`CTRL_SLOAD_EN_BOT];

  cell_register u_top_register (
    .clk(clk),
    .clr_n(clr_n),
    .ena(reg_ena),
    .sclr(top_sclr),
    .sload(top_sload),
    .sdata(lut_in_c),
    .d(top_d),
    .q(top_q)
  );

  // Bottom register is not available in extended mode
  cell_register u_bottom_register (
    .clk(clk),
    .clr_n(clr_n),
    .ena(reg_ena & !is_ext),
    .sclr(bot_sclr),
    .sload(bot_sload),
    .sdata(lut_in_d),
    .d(bot_d),
    .q(bot_q)
  );

  // Third register loads lut_in_e1, on clock, clear and clk_ena only, with no sclr or sload
  cell_register u_lut_register (
    .clk(clk),
    .clr_n(clr_n),
    .ena(clk_ena & is_lutreg),
    .sclr(1'b0),
    .sload(1'b0),
    .sdata(1'b0),
    .d(lut_in_e1),
    .q(lut_q)
  );

  assign top_reg_out = top_q;
  assign bot_reg_out = bot_q;
  assign lut_reg_out = lut_q;
  assign reg_chain_out = bot_q;

  // Read data stands only in the cycle after the read strobe
  always @* begin
    rdata_nxt = 32'h00000000;
    if (rd) begin
      case (addr)
        `OFS_CTRL: rdata_nxt = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_r};
        `OFS_TOP_MASK_LO: rdata_nxt = top_lo_r;
        `OFS_TOP_MASK_HI: rdata_nxt = top_hi_r;
        `OFS_BOT_MASK_LO: rdata_nxt = bot_lo_r;
        `OFS_BOT_MASK_HI: rdata_nxt = bot_hi_r;
        `OFS_STATUS: rdata_nxt = {21'h000000, mode, bypass_ok, start_ok, mode_bad,
          share_out, carry_out, lut_q, bot_q, top_q};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rdata_nxt;
    end
  end

endmodule // logic_cell

`default_nettype wire

// ### verification/prev_cell.sv
`default_nettype none
// Previous cell of the cluster, feeding the chain inputs
module prev_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Values this cell produces
  input wire logic [2:0] src,
  // Chain toward the next cell
  output logic carry_src,
  output logic share_src,
  output var logic chain_q
);
  timeunit 1ns;
  timeprecision 1ns;
  assign carry_src = src[0];
  assign share_src = src[1];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chain_q <= 1'b0;
    end else begin
      chain_q <= src[2];
    end
  end
endmodule // prev_cell
`default_nettype wire

// ### verification/logic_cell_checker.sv
`default_nettype none
module logic_cell_checker #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Cluster controls
  input wire logic clk_ena,
  input wire logic aclr_n,
  input wire logic chip_wide_clear_n,
  // Register outputs
  input wire logic reg_chain_out,
  input wire logic top_reg_out,
  input wire logic bot_reg_out,
  input wire logic lut_reg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_r;
  logic clr_n;
  assign clr_n = aclr_n && chip_wide_clear_n;
  // Raw mode code last written, followed from control writes; codes above 4 kept as written
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= 3'h0;
    end else if (wr && addr == 'h0) begin
      mode_r <= wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_mode_readback: assert property (wr && addr == 'h0 ##1 !wr ##1 rd && addr == 'h0 |=>
    rdata[2:0] == $past(wdata[2:0], 3)) else $error("mode readback wrong");
  a_chip_clear_all: assert property (!chip_wide_clear_n |->
    !top_reg_out && !bot_reg_out && !lut_reg_out) else $error("chip clear missed");
  a_aclr_regs: assert property (!aclr_n |->
    !top_reg_out && !bot_reg_out && !lut_reg_out) else $error("cluster clear missed");
  a_ena_hold_top: assert property (!clk_ena ##1 clr_n |-> $stable(top_reg_out))
    else $error("top moved without enable");
  a_ena_hold_bot: assert property (!clk_ena ##1 clr_n |-> $stable(bot_reg_out))
    else $error("bottom moved without enable");
  a_lutreg_ena: assert property (!clk_ena ##1 clr_n |-> $stable(lut_reg_out))
    else $error("third register moved without enable");
  a_chain_is_bot: assert property (reg_chain_out == bot_reg_out)
    else $error("chain output differs");
  a_ext_bot_frozen: assert property (mode_r == 3'h1 ##1 clr_n |-> $stable(bot_reg_out))
    else $error("bottom moved in extended mode");
  c_arith: cover property (mode_r == 3'h2 ##1 top_reg_out);
  c_shared: cover property (mode_r == 3'h3);
  c_chip_clear: cover property (!chip_wide_clear_n);
endmodule // logic_cell_checker
bind logic_cell logic_cell_checker #(.ADDR_W(ADDR_W)) u_logic_cell_checker (.clk(clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .clk_ena(clk_ena), .aclr_n(aclr_n), .chip_wide_clear_n(chip_wide_clear_n),
  .reg_chain_out(reg_chain_out), .top_reg_out(top_reg_out), .bot_reg_out(bot_reg_out),
  .lut_reg_out(lut_reg_out));
`default_nettype wire

// ### verification/logic_cell_tb.sv
`default_nettype none
module logic_cell_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clk_ena = 1'b1;
  logic aclr_n = 1'b1;
  logic sclr = 1'b0;
  logic sload = 1'b0;
  logic cwc_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] din = 8'h00;
  logic [2:0] src = 3'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata, rs, d;
  logic [63:0] tm, bm;
  logic [3:0] e, pe;
  logic [7:0] pd;
  logic [2:0] ch;
  logic cin, sin, chin, cout, sout, top_c, top_q, bot_c, bot_q, lut_q, rco;
  logic [14:0] cw [11] = '{15'h0000, 15'h0001, 15'h0002, 15'h0003, 15'h0802, 15'h0004,
    15'h0060, 15'h4002, 15'h5002, 15'h2000, 15'h0018};
  logic [4:0] st [5] = '{5'h11, 5'h14, 5'h1E, 5'h06, 5'h17};
  int fail_count = 0;
  int checks = 0;
  always #20 clk = ~clk;
  prev_cell u_prev_cell (.clk(clk), .nrst(nrst), .src(src), .carry_src(cin),
    .share_src(sin), .chain_q(chin));
  logic_cell u_logic_cell (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clk_ena(clk_ena), .aclr_n(aclr_n), .sclr(sclr), .sload(sload),
    .chip_wide_clear_n(cwc_n), .lut_in_a(din[0]), .lut_in_b(din[1]), .lut_in_c(din[2]),
    .lut_in_d(din[3]), .lut_in_e0(din[4]), .lut_in_f0(din[5]), .lut_in_e1(din[6]),
    .lut_in_f1(din[7]), .carry_in(cin), .share_in(sin), .reg_chain_in(chin),
    .carry_out(cout), .share_out(sout), .reg_chain_out(rco), .top_comb_out(top_c),
    .top_reg_out(top_q), .bot_comb_out(bot_c), .bot_reg_out(bot_q), .lut_reg_out(lut_q));
  function automatic logic [31:0] nx();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Expected {q3, carry, bottom, top} for a control word, inputs and chain inputs
  function automatic logic [3:0] want(input logic [14:0] c, input logic [7:0] i,
    input logic [2:0] s);
    logic q0, q1, q2, q3, v, ci, si;
    logic [1:0] s0, s1;
    q0 = tm[{i[4], i[2:0]}];
    q1 = tm[{2'h1, i[5], i[3], i[1:0]}];
    q2 = bm[{i[6], i[2:0]}];
    q3 = bm[{2'h1, i[7], i[3], i[1:0]}];
    // Local sub or down inverts the second operands; a chain start seeds the carry
    v = (c[2:0] == 3'h2) && c[14] && !(i[4] && i[6]);
    ci = c[12] ? v : s[0];
    si = c[12] ? 1'b0 : s[1];
    s0 = q0 + (c[0] ? si : q1 ^ v) + ci;
    s1 = q2 + (c[0] ? q1 : q3 ^ v) + s0[1];
    if (c[2:0] == 3'h0 || c[2:0] == 3'h4) return {2'h0, bm[{i[7:6], i[3:0]}], tm[i[5:0]]};
    if (c[2:0] == 3'h1) return {3'h0, i[5] ? bm[{i[6], i[3:0]}] : tm[{i[4], i[3:0]}]};
    return {q3, s1[1], s1[0], s0[0]};
  endfunction
  task automatic cmp_bit(input logic g, input logic x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic wtab();
    wreg(8'h04, tm[31:0]);
    wreg(8'h08, tm[63:32]);
    wreg(8'h0C, bm[31:0]);
    wreg(8'h10, bm[63:32]);
  endtask
  task automatic summarize();
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    rs = 32'hA08123BF;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      wreg(8'h00, m);
      rreg(8'h00, d);
      cmp_word(d, m);
      rreg(8'h14, d);
      cmp_word(d & 32'h00000700, (m > 4 ? 0 : m) << 8);
      cmp_word(d & 32'h00000020, m > 4 ? 32'h00000020 : 32'h00000000);
      cmp_word(d & 32'h000000C0, 32'h000000C0);
    end
    wreg(8'h20, nx());
    rreg(8'h20, d);
    cmp_word(d, 32'h00000000);
    for (int k = 0; k < 11; k++) begin
      tm = {nx(), nx()};
      bm = {nx(), nx()};
      wtab();
      rreg(8'h10, d);
      cmp_word(d, bm[63:32]);
      wreg(8'h00, {17'h0, cw[k]});
      for (int n = 0; n < 12; n++) begin
        @(posedge clk);
        // First cycle keeps the local enables high so the registers start known
        d = nx() | (n == 0 ? 32'h000000A0 : 32'h00000000);
        din <= d[7:0];
        src <= d[10:8];
        @(negedge clk);
        e = want(cw[k], d[7:0], d[10:8]);
        if (k != 4) cmp_bit(bot_c, e[1]);
        if (k != 4) cmp_bit(top_c, e[0]);
        if (k == 2 || k == 3) cmp_bit(bot_c, e[1]);
        if (k != 9) cmp_bit(cout, e[2]);
        if (k == 3) cmp_bit(sout, e[3]);
        if (k == 4) cmp_bit(top_c, tm[{d[4], d[2:0]}]);
        if (k == 4) cmp_bit(bot_c, bm[{d[6], d[2:0]}]);
        if (k == 9) cmp_bit(cout, d[8]);
        if (k == 9) cmp_bit(sout, d[9]);
        if (n > 0 && (k < 5 || k == 9)) cmp_bit(top_q, pe[0]);
        if (n > 0 && (k == 0 || (k > 1 && k < 5) || k == 9)) cmp_bit(bot_q, pe[1]);
        if (n > 0 && k > 6 && k < 9) cmp_bit(top_q, pe[0]);
        if (n > 0 && k > 6 && k < 9) cmp_bit(bot_q, pe[1]);
        if (n > 0 && k == 5) cmp_bit(lut_q, pd[6]);
        if (n > 0 && k == 10) cmp_bit(top_q, pd[4]);
        if (n > 0 && k == 10) cmp_bit(bot_q, pd[7]);
        if (n > 2 && k == 6) cmp_bit(top_q, ch[1]);
        if (n > 2 && k == 6) cmp_bit(bot_q, ch[2]);
        if (n > 2 && k == 6) cmp_bit(rco, ch[2]);
        // Registers only take new values while both local enables are high
        if (!cw[k][14] || (d[5] && d[7])) pe = e;
        pd = d[7:0];
        ch = {ch[1:0], d[10]};
      end
    end
    tm = '1;
    bm = '1;
    wtab();
    wreg(8'h00, 32'h00000180);
    foreach (st[j]) begin
      @(posedge clk);
      {clk_ena, sclr, sload} <= st[j][4:2];
      din <= {5'h00, st[j][1], 2'h0};
      @(posedge clk);
      @(negedge clk);
      cmp_bit(top_q, st[j][0]);
    end
    @(posedge clk);
    aclr_n <= 1'b0;
    @(negedge clk);
    cmp_bit(top_q, 1'b0);
    @(posedge clk);
    aclr_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp_bit(top_q, 1'b1);
    @(posedge clk);
    cwc_n <= 1'b0;
    @(negedge clk);
    cmp_bit(top_q | bot_q | lut_q, 1'b0);
    @(posedge clk);
    cwc_n <= 1'b1;
    summarize();
  end
endmodule // logic_cell_tb
`default_nettype wire
